// file: pkg/content_protect_params.svh
`ifndef CONTENT_PROTECT_PARAMS_SVH
`define CONTENT_PROTECT_PARAMS_SVH

// register byte addresses
`define ADDR_TOPO_STATUS   8'hA2
`define ADDR_KEY_FIFO      8'hA3
`define ADDR_DEBUG_CTRL    8'hC0
`define ADDR_CONFIG        8'hC2
`define ADDR_IND_STATUS    8'hE0
`define ADDR_IRQ_STATUS    8'hE1
`define ADDR_IRQ_MASK      8'hE2

// topology status fields
`define TOPO_OVF_BIT       3
`define TOPO_DEPTH_MSB     2
`define MAX_CASCADE        4'h7

// debug control fields
`define DBG_TIMEOUT_OFF    6
`define DBG_SYNC_OFF       4
`define DBG_LINE_CHK       3
`define DBG_FC_FAST        2
`define DBG_TMR_FAST       1
`define DBG_BUS_FAST       0
`define DBG_WRITE_MASK     8'h5F
`define DBG_RESET          8'h00

// configuration fields
`define CFG_ENH_LINK       7
`define CFG_ENHANCED_STATUS_SIGNALLING           6
`define CFG_REPEATER       5
`define CFG_AV_MUTE        0
`define CFG_RESET          8'hA8

// indirect status fields
`define IND_BUS_FAST       0

// interrupt status fields
`define IRQ_KEY_READY      0
`define IRQ_CASC_OVF       1
`define IRQ_BUS_TIMEOUT    2
`define IRQ_LINE_CHK       3
`define IRQ_WIDTH          4

// frame period masks (period minus one)
`define RI_MASK_NORM       7'h7F
`define RI_MASK_FAST       7'h0F
`define PJ_MASK_NORM       7'h0F
`define PJ_MASK_FAST       7'h01

// bus timeout
`define CLK_HZ             50000000
`define BUS_TIMEOUT_S      1

`endif

// file: pkg/content_protect_pkg.sv
package content_protect_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef logic [6:0] frame_cnt_t;
	typedef logic [3:0] irq_bits_t;
endpackage

// file: verilog/content_protect_tx_debug_cfg_regs.sv
// Operation
// - topology bit 3 flags a repeater chain deeper than seven levels.
// - topology bits 2:0 report attached cascade depth.
// - each key list port read returns the next list byte, zero once the list is exhausted.
// - bus assumed free after over one second idle unless timeout disabled.
// - integrity value checked before and after frame 128, frame 127 syncs.
// - sync check off bit skips frame 127 check, keeps the other.
// - line checksum bit sends ones-complement sum per colour channel per line.
// - fast frame counter: verify every 2/16 frames, else every 16/128.
// - timer speedup bit shortens authentication timers.
// - bus fast bit selects fast or standard timing.
// - bus fast bit mirrored in indirect status register.
// - enhanced link check bit enables verification every 16th frame, every 2nd with the fast frame counter.
// - configuration bit 6 selects enhanced or original status signalling.
// - configuration bit 5 enables repeater mode.
// - configuration register resets to 0xA8.
`timescale 1ns/10ps
`include "content_protect_params.svh"

module content_protect_tx_debug_cfg_regs #(
	parameter int KEY_LIST_DEPTH     = 635,
	parameter int KEY_PTR_W          = 10,
	parameter int TIMEOUT_W          = 27,
	parameter int BUS_TIMEOUT_CYCLES = `BUS_TIMEOUT_S * `CLK_HZ + 1
) (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [7:0]  addr,
	input  wire logic [7:0]  wrData,
	input  wire logic        wrEn,
	input  wire logic        rdEn,
	output logic      [7:0]  rdData,
	input  wire logic        topoUpdate,
	input  wire logic [3:0]  cascadeLevels,
	input  wire logic        keyByteValid,
	input  wire logic [7:0]  keyByte,
	input  wire logic        keyListReady,
	input  wire logic        busActivity,
	input  wire logic        frameStart,
	input  wire logic        pixelValid,
	input  wire logic [23:0] pixel,
	input  wire logic        lineEnd,
	output logic             busTimedOut,
	output logic             integrityCheck,
	output logic             integritySyncCheck,
	output logic             enhancedVerifyCheck,
	output logic             lineChecksumValid,
	output logic      [23:0] lineChecksum,
	output logic             busFastTiming,
	output logic             authTimerFast,
	output logic             enhancedSignalling,
	output logic             repeaterMode,
	output logic             avMute,
	output logic             irq
);

	content_protect_pkg::reg_byte_t  topoStatus;
	content_protect_pkg::reg_byte_t  debugCtrl;
	content_protect_pkg::reg_byte_t  protConfig;
	content_protect_pkg::irq_bits_t  irqStatus;
	content_protect_pkg::irq_bits_t  irqMask;
	content_protect_pkg::irq_bits_t  irqEvents;
	content_protect_pkg::frame_cnt_t frameCnt;
	content_protect_pkg::frame_cnt_t next_frameCnt;
	content_protect_pkg::frame_cnt_t riMask;
	content_protect_pkg::frame_cnt_t pjMask;

	logic [7:0]           keyMem [KEY_LIST_DEPTH];
	logic [KEY_PTR_W-1:0] keyWrPtr;
	logic [KEY_PTR_W-1:0] keyRdPtr;
	logic [KEY_PTR_W-1:0] keyCount;
	logic [TIMEOUT_W-1:0] idleCnt;
	logic [7:0]           sumRed;
	logic [7:0]           sumGreen;
	logic [7:0]           sumBlue;
	logic                 cascOverflowEvt;
	logic                 busTimeoutEvt;

	logic wrDebug;
	logic wrConfig;
	logic wrIrqStatus;
	logic wrIrqMask;
	logic rdKey;

	assign wrDebug     = wrEn && addr == `ADDR_DEBUG_CTRL;
	assign wrConfig    = wrEn && addr == `ADDR_CONFIG;
	assign wrIrqStatus = wrEn && addr == `ADDR_IRQ_STATUS;
	assign wrIrqMask   = wrEn && addr == `ADDR_IRQ_MASK;
	assign rdKey       = rdEn && addr == `ADDR_KEY_FIFO;

	// end-around carry addition for the line checksum
	function automatic logic [7:0] onesAdd(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		onesAdd = s[7:0] + {7'h00, s[8]};
	endfunction

	// true when the frame index sits at the given phase of a power-of-two period
	function automatic logic periodHit(input logic [6:0] cnt, input logic [6:0] mask,
		input logic [6:0] phase);
		periodHit = (cnt & mask) == (phase & mask);
	endfunction

	// ---------------- software registers ----------------

	always_ff @(posedge clk) begin
		if (rst) begin
			protConfig <= `CFG_RESET;
		end else if (wrConfig) begin
			protConfig <= wrData;
		end
	end

	// reserved debug bits are kept at zero
	always_ff @(posedge clk) begin
		if (rst) begin
			debugCtrl <= `DBG_RESET;
		end else if (wrDebug) begin
			debugCtrl <= wrData & `DBG_WRITE_MASK;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irqMask <= '0;
		end else if (wrIrqMask) begin
			irqMask <= wrData[`IRQ_WIDTH-1:0];
		end
	end

	// ---------------- receiver topology ----------------

	always_ff @(posedge clk) begin
		if (rst) begin
			topoStatus <= 8'h00;
		end else if (topoUpdate) begin
			topoStatus <= 8'h00;
			if (cascadeLevels > `MAX_CASCADE) begin
				topoStatus[`TOPO_OVF_BIT]      <= 1'b1;
				topoStatus[`TOPO_DEPTH_MSB:0]  <= 3'h7;
			end else begin
				topoStatus[`TOPO_DEPTH_MSB:0]  <= cascadeLevels[2:0];
			end
		end
	end

	assign cascOverflowEvt = topoUpdate && cascadeLevels > `MAX_CASCADE;

	// ---------------- key list buffer ----------------

	// bytes past the depth are dropped; the list is bounded by the device count
	always_ff @(posedge clk) begin
		if (keyByteValid && keyWrPtr < KEY_PTR_W'(KEY_LIST_DEPTH)) begin
			keyMem[keyWrPtr] <= keyByte;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			keyWrPtr <= '0;
			keyCount <= '0;
		end else if (keyListReady) begin
			keyCount <= keyWrPtr + KEY_PTR_W'(keyByteValid);
			keyWrPtr <= '0;
		end else if (keyByteValid && keyWrPtr < KEY_PTR_W'(KEY_LIST_DEPTH)) begin
			keyWrPtr <= keyWrPtr + KEY_PTR_W'(1);
		end
	end

	// restart read position on new list
	always_ff @(posedge clk) begin
		if (rst) begin
			keyRdPtr <= '0;
		end else if (keyListReady) begin
			keyRdPtr <= '0;
		end else if (rdKey && keyRdPtr < keyCount) begin
			keyRdPtr <= keyRdPtr + KEY_PTR_W'(1);
		end
	end

	// ---------------- read port ----------------

	always_ff @(posedge clk) begin
		if (rst) begin
			rdData <= 8'h00;
		end else if (rdEn) begin
			unique case (addr)
				`ADDR_TOPO_STATUS: rdData <= topoStatus;
				// key byte, zero once the list is exhausted
				`ADDR_KEY_FIFO:    rdData <= (keyRdPtr < keyCount) ? keyMem[keyRdPtr] : 8'h00;
				`ADDR_DEBUG_CTRL:  rdData <= debugCtrl;
				`ADDR_CONFIG:      rdData <= protConfig;
				`ADDR_IND_STATUS:  rdData <= {7'h00, debugCtrl[`DBG_BUS_FAST]};
				`ADDR_IRQ_STATUS:  rdData <= {4'h0, irqStatus};
				`ADDR_IRQ_MASK:    rdData <= {4'h0, irqMask};
				default:           rdData <= 8'h00;
			endcase
		end else begin
			rdData <= 8'h00;
		end
	end

	// ---------------- protection bus timeout ----------------

	// idle count toward the one second limit
	always_ff @(posedge clk) begin
		if (rst) begin
			idleCnt <= '0;
		end else if (busActivity || debugCtrl[`DBG_TIMEOUT_OFF]) begin
			idleCnt <= '0;
		end else if (idleCnt < TIMEOUT_W'(BUS_TIMEOUT_CYCLES)) begin
			idleCnt <= idleCnt + TIMEOUT_W'(1);
		end
	end

	assign busTimeoutEvt = !busActivity && !debugCtrl[`DBG_TIMEOUT_OFF]
		&& idleCnt == TIMEOUT_W'(BUS_TIMEOUT_CYCLES - 1);

	// bus assumed free until new activity or timeout disable
	always_ff @(posedge clk) begin
		if (rst) begin
			busTimedOut <= 1'b0;
		end else if (busActivity || debugCtrl[`DBG_TIMEOUT_OFF]) begin
			busTimedOut <= 1'b0;
		end else if (busTimeoutEvt) begin
			busTimedOut <= 1'b1;
		end
	end

	// ---------------- frame counter and link checks ----------------

	// periods follow the fast test bit
	assign riMask        = debugCtrl[`DBG_FC_FAST] ? `RI_MASK_FAST : `RI_MASK_NORM;
	assign pjMask        = debugCtrl[`DBG_FC_FAST] ? `PJ_MASK_FAST : `PJ_MASK_NORM;
	assign next_frameCnt = frameCnt + 7'h01;

	always_ff @(posedge clk) begin
		if (rst) begin
			frameCnt <= 7'h00;
		end else if (frameStart) begin
			frameCnt <= next_frameCnt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			integrityCheck <= 1'b0;
		end else begin
			integrityCheck <= frameStart && periodHit(next_frameCnt, riMask, 7'h00);
		end
	end

	// skipped when sync check is off
	always_ff @(posedge clk) begin
		if (rst) begin
			integritySyncCheck <= 1'b0;
		end else begin
			integritySyncCheck <= frameStart && !debugCtrl[`DBG_SYNC_OFF]
				&& periodHit(next_frameCnt, riMask, riMask);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			enhancedVerifyCheck <= 1'b0;
		end else begin
			enhancedVerifyCheck <= frameStart && protConfig[`CFG_ENH_LINK]
				&& periodHit(next_frameCnt, pjMask, 7'h00);
		end
	end

	// ---------------- line checksum ----------------

	always_ff @(posedge clk) begin
		if (rst || lineEnd) begin
			sumRed   <= 8'h00;
			sumGreen <= 8'h00;
			sumBlue  <= 8'h00;
		end else if (pixelValid) begin
			sumRed   <= onesAdd(sumRed, pixel[23:16]);
			sumGreen <= onesAdd(sumGreen, pixel[15:8]);
			sumBlue  <= onesAdd(sumBlue, pixel[7:0]);
		end
	end

	// sent after line end when enabled
	always_ff @(posedge clk) begin
		if (rst) begin
			lineChecksumValid <= 1'b0;
			lineChecksum      <= 24'h000000;
		end else begin
			lineChecksumValid <= lineEnd && debugCtrl[`DBG_LINE_CHK];
			if (lineEnd && debugCtrl[`DBG_LINE_CHK]) begin
				lineChecksum <= ~{sumRed, sumGreen, sumBlue};
			end
		end
	end

	// ---------------- control outputs ----------------

	always_ff @(posedge clk) begin
		if (rst) begin
			busFastTiming      <= 1'b0;
			authTimerFast      <= 1'b0;
			enhancedSignalling <= 1'b0;
			repeaterMode       <= 1'b0;
		end else begin
			busFastTiming      <= debugCtrl[`DBG_BUS_FAST];
			authTimerFast      <= debugCtrl[`DBG_TMR_FAST];
			enhancedSignalling <= protConfig[`CFG_ENHANCED_STATUS_SIGNALLING];
			repeaterMode       <= protConfig[`CFG_REPEATER];
		end
	end

	// mute honoured only with enhanced signalling, guarding software misuse
	always_ff @(posedge clk) begin
		if (rst) begin
			avMute <= 1'b0;
		end else begin
			avMute <= protConfig[`CFG_AV_MUTE] && protConfig[`CFG_ENHANCED_STATUS_SIGNALLING];
		end
	end

	// ---------------- interrupts ----------------

	always_comb begin
		irqEvents                   = '0;
		irqEvents[`IRQ_KEY_READY]   = keyListReady;
		irqEvents[`IRQ_CASC_OVF]    = cascOverflowEvt;
		irqEvents[`IRQ_BUS_TIMEOUT] = busTimeoutEvt;
		irqEvents[`IRQ_LINE_CHK]    = lineEnd && debugCtrl[`DBG_LINE_CHK];
	end

	// a new event wins over a write-one clear in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			irqStatus <= '0;
		end else begin
			irqStatus <= (irqStatus & ~(wrIrqStatus ? wrData[`IRQ_WIDTH-1:0] : 4'h0)) | irqEvents;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irqStatus & irqMask);
		end
	end

endmodule

// file: verif/cp_regs_monitor.sv
`timescale 1ns/10ps
module cp_regs_monitor #(
	parameter int BUS_TIMEOUT_CYCLES = 20
) (
	input wire logic       clk,
	input wire logic       rst,
	input wire logic [7:0] addr,
	input wire logic       wrEn,
	input wire logic       rdEn,
	input wire logic [7:0] rdData,
	input wire logic       busActivity,
	input wire logic       frameStart,
	input wire logic       lineEnd,
	input wire logic       busTimedOut,
	input wire logic       integrityCheck,
	input wire logic       integritySyncCheck,
	input wire logic       enhancedVerifyCheck,
	input wire logic       lineChecksumValid,
	input wire logic       busFastTiming,
	input wire logic       authTimerFast,
	input wire logic       enhancedSignalling,
	input wire logic       avMute
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	int idle;
	// saturates so a late rise after re-enable still matches
	always_ff @(posedge clk) begin
		if (rst || busActivity) begin
			idle <= 0;
		end else if (idle < BUS_TIMEOUT_CYCLES) begin
			idle <= idle + 1;
		end
	end
	sequence dbg_written;
		$past(wrEn, 2) && $past(addr, 2) == 8'hC0;
	endsequence
	chk_read_idle_zero: assert property (!$past(rdEn) |-> rdData == 8'h00)
		else $error("read data outside read cycle");
	chk_integ_frame: assert property (integrityCheck |-> $past(frameStart))
		else $error("integrity pulse without frame");
	chk_sync_frame: assert property (integritySyncCheck |-> $past(frameStart) && !integrityCheck)
		else $error("sync pulse misplaced");
	chk_verify_frame: assert property (enhancedVerifyCheck |-> $past(frameStart))
		else $error("verify pulse without frame");
	chk_line_sum: assert property (lineChecksumValid |-> $past(lineEnd))
		else $error("checksum not after line end");
	chk_mute_gate: assert property (avMute |-> enhancedSignalling)
		else $error("mute without enhanced signalling");
	chk_activity_frees: assert property (busActivity |=> !busTimedOut)
		else $error("timeout despite activity");
	chk_timeout_count: assert property ($rose(busTimedOut) |-> idle == BUS_TIMEOUT_CYCLES)
		else $error("timeout at wrong count");
	chk_fast_source: assert property ($changed(busFastTiming) |-> dbg_written)
		else $error("bus timing changed without write");
	chk_timer_source: assert property ($changed(authTimerFast) |-> dbg_written)
		else $error("timer speed changed without write");
endmodule
bind content_protect_tx_debug_cfg_regs cp_regs_monitor #(.BUS_TIMEOUT_CYCLES(BUS_TIMEOUT_CYCLES)) u_mon (
	.clk(clk), .rst(rst), .addr(addr), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
	.busActivity(busActivity), .frameStart(frameStart), .lineEnd(lineEnd), .busTimedOut(busTimedOut),
	.integrityCheck(integrityCheck), .integritySyncCheck(integritySyncCheck),
	.enhancedVerifyCheck(enhancedVerifyCheck), .lineChecksumValid(lineChecksumValid),
	.busFastTiming(busFastTiming), .authTimerFast(authTimerFast),
	.enhancedSignalling(enhancedSignalling), .avMute(avMute));

// file: verif/downstream_rx_model.sv
`timescale 1ns/10ps
module downstream_rx_model (
	input wire logic  clk,
	output logic       topoUpdate,
	output logic [3:0] cascadeLevels,
	output logic       keyByteValid,
	output logic [7:0] keyByte,
	output logic       keyListReady
);
	initial begin
		topoUpdate = 1'b0;
		cascadeLevels = 4'hF;
		keyByteValid = 1'b0;
		keyByte = 8'hA5;
		keyListReady = 1'b0;
	end
	// released lines show the inverse, never a stale value
	task automatic put_topo(input logic [3:0] lv);
		@(posedge clk);
		topoUpdate <= 1'b1;
		cascadeLevels <= lv;
		@(posedge clk);
		topoUpdate <= 1'b0;
		cascadeLevels <= ~lv;
	endtask
	task automatic put_list(input logic [7:0] q[$]);
		foreach (q[i]) begin
			@(posedge clk);
			keyByteValid <= 1'b1;
			keyByte <= q[i];
		end
		@(posedge clk);
		keyByteValid <= 1'b0;
		keyByte <= ~keyByte;
		keyListReady <= 1'b1;
		@(posedge clk);
		keyListReady <= 1'b0;
	endtask
endmodule

// file: verif/test_content_protect_tx_debug_cfg_regs.sv
`timescale 1ns/10ps
`define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin failures++; \
	$display("Error t=%0t got %h exp %h", $time, g, x); end end
module test_content_protect_tx_debug_cfg_regs;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic [7:0]  wrData = 8'h00;
	logic        wrEn = 1'b0;
	logic        rdEn = 1'b0;
	logic        rdSeen = 1'b0;
	logic        busActivity = 1'b1;
	logic        frameStart = 1'b0;
	logic        pixelValid = 1'b0;
	logic [23:0] pixel = 24'h000000;
	logic        lineEnd = 1'b0;
	logic [7:0]  nI = 8'h00, nS = 8'h00, nE = 8'h00;
	logic [7:0]  rdData, keyByte, s0, s1, s2, e;
	logic [3:0]  cascadeLevels;
	logic [23:0] lineChecksum, sum, px;
	logic        topoUpdate, keyByteValid, keyListReady, busTimedOut, integrityCheck, integritySyncCheck;
	logic        enhancedVerifyCheck, lineChecksumValid, busFastTiming, authTimerFast;
	logic        enhancedSignalling, repeaterMode, avMute, irq;
	logic [7:0]  expQ[$];
	logic [7:0]  kq[$];
	logic [7:0]  ft[4][6] = '{'{8'h04, 8'h80, 8'd32, 8'd2, 8'd2, 8'd16}, '{8'h14, 8'h80, 8'd32, 8'd2, 8'd0, 8'd16},
		'{8'h00, 8'h80, 8'd128, 8'd1, 8'd1, 8'd8}, '{8'h04, 8'h00, 8'd16, 8'd1, 8'd1, 8'd0}};
	int          failures = 0, samples_checked = 0, seed = 26, cycles = 0;
	content_protect_tx_debug_cfg_regs #(.BUS_TIMEOUT_CYCLES(20)) u_dut (.clk(clk), .rst(rst), .addr(addr),
		.wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .topoUpdate(topoUpdate),
		.cascadeLevels(cascadeLevels), .keyByteValid(keyByteValid), .keyByte(keyByte), .keyListReady(keyListReady),
		.busActivity(busActivity), .frameStart(frameStart), .pixelValid(pixelValid), .pixel(pixel),
		.lineEnd(lineEnd), .busTimedOut(busTimedOut), .integrityCheck(integrityCheck),
		.integritySyncCheck(integritySyncCheck), .enhancedVerifyCheck(enhancedVerifyCheck),
		.lineChecksumValid(lineChecksumValid), .lineChecksum(lineChecksum), .busFastTiming(busFastTiming),
		.authTimerFast(authTimerFast), .enhancedSignalling(enhancedSignalling), .repeaterMode(repeaterMode),
		.avMute(avMute), .irq(irq));
	downstream_rx_model u_rx (.clk(clk), .topoUpdate(topoUpdate), .cascadeLevels(cascadeLevels),
		.keyByteValid(keyByteValid), .keyByte(keyByte), .keyListReady(keyListReady));
	always #10 clk = ~clk;
	task automatic give_verdict();
		$display("checked %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			give_verdict();
		end
	end
	always @(posedge clk) begin
		if (rdSeen) begin
			e = expQ.pop_front();
			`CHK(rdData, e)
		end
		rdSeen <= rdEn;
		nI <= nI + integrityCheck;
		nS <= nS + integritySyncCheck;
		nE <= nE + enhancedVerifyCheck;
	end
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		rdEn <= 1'b0;
		wrEn <= 1'b1;
		addr <= a;
		wrData <= d;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] x);
		@(posedge clk);
		wrEn <= 1'b0;
		rdEn <= 1'b1;
		addr <= a;
		expQ.push_back(x);
	endtask
	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clk);
			wrEn <= 1'b0;
			rdEn <= 1'b0;
		end
	endtask
	function automatic logic [23:0] oc(input logic [23:0] s, input logic [23:0] p);
		logic [8:0] t;
		for (int c = 0; c < 24; c += 8) begin
			t = s[c+:8] + p[c+:8];
			oc[c+:8] = t[7:0] + t[8];
		end
	endfunction
	initial begin
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		idle(2);
		@(negedge clk);
		`CHK({repeaterMode, enhancedSignalling, avMute}, 3'b100)
		rd(8'hC2, 8'hA8);
		rd(8'hC0, 8'h00);
		rd(8'hA2, 8'h00);
		rd(8'h55, 8'h00);
		idle(3);
		$display("reset test done");
		for (int i = 0; i < 6; i++) begin
			s0 = 8'($random(seed));
			// software asks for mute only with enhanced signalling
			s0[0] = s0[0] & s0[6];
			wr(8'hC2, s0);
			wr(8'hC0, s0);
			rd(8'hC2, s0);
			rd(8'hC0, s0 & 8'h5F);
			rd(8'hE0, {7'h00, s0[0]});
			idle(3);
			@(negedge clk);
			`CHK({enhancedSignalling, repeaterMode, avMute}, {s0[6], s0[5], s0[6] & s0[0]})
			`CHK({busFastTiming, authTimerFast}, {s0[0], s0[1]})
		end
		$display("config test done");
		u_rx.put_topo(4'h3);
		rd(8'hA2, 8'h03);
		wr(8'hE1, 8'h0F);
		wr(8'hE2, 8'h02);
		idle(1);
		u_rx.put_topo(4'h9);
		wr(8'hA2, 8'hFF);
		rd(8'hA2, 8'h0F);
		idle(3);
		@(negedge clk);
		`CHK(irq, 1'b1)
		wr(8'hE2, 8'h00);
		rd(8'hE1, 8'h02);
		idle(3);
		@(negedge clk);
		`CHK(irq, 1'b0)
		wr(8'hE2, 8'h02);
		wr(8'hE1, 8'h02);
		idle(3);
		@(negedge clk);
		`CHK(irq, 1'b0)
		$display("topology test done");
		for (int n = 7; n > 2; n -= 4) begin
			kq.delete();
			repeat (n) kq.push_back(8'($random(seed)));
			idle(1);
			u_rx.put_list(kq);
			foreach (kq[j]) rd(8'hA3, kq[j]);
			rd(8'hA3, 8'h00);
		end
		idle(3);
		$display("key list test done");
		foreach (ft[k]) begin
			wr(8'hC0, ft[k][0]);
			wr(8'hC2, ft[k][1]);
			idle(3);
			s0 = nI;
			s1 = nS;
			s2 = nE;
			for (int f = 0; f < ft[k][2]; f++) begin
				@(posedge clk) frameStart <= 1'b1;
				@(posedge clk) frameStart <= 1'b0;
			end
			idle(3);
			`CHK(nI - s0, ft[k][3])
			`CHK(nS - s1, ft[k][4])
			`CHK(nE - s2, ft[k][5])
		end
		$display("frame test done");
		wr(8'hC0, 8'h08);
		idle(2);
		sum = 24'h000000;
		repeat (5) begin
			px = 24'($random(seed));
			sum = oc(sum, px);
			@(posedge clk);
			pixelValid <= 1'b1;
			pixel <= px;
		end
		@(posedge clk);
		pixelValid <= 1'b0;
		lineEnd <= 1'b1;
		@(posedge clk);
		lineEnd <= 1'b0;
		@(negedge clk);
		`CHK({lineChecksumValid, lineChecksum}, {1'b1, ~sum})
		$display("checksum test done");
		wr(8'hE1, 8'h0F);
		idle(1);
		busActivity <= 1'b0;
		idle(22);
		@(negedge clk);
		`CHK(busTimedOut, 1'b1)
		rd(8'hE1, 8'h04);
		wr(8'hC0, 8'h40);
		idle(30);
		@(negedge clk);
		`CHK(busTimedOut, 1'b0)
		$display("timeout test done");
		give_verdict();
	end
endmodule
